// [fpes_pkg.sv]
package fpes_pkg;
    // flash command codes
    localparam logic [7:0] CMD_PROGRAM   = 8'h40;
    localparam logic [7:0] CMD_ERASE     = 8'h20;
    localparam logic [7:0] CMD_CONFIRM   = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_CLEAR     = 8'h50;
    localparam logic [7:0] CMD_READ      = 8'hFF;
    localparam logic [7:0] CMD_PROT_PROG = 8'hC0;
    // write_status field positions
    localparam int READY_BIT      = 7;
    localparam int ERASE_SUSP_BIT = 6;
    localparam int ERASE_ERR_BIT  = 5;
    localparam int PROG_ERR_BIT   = 4;
    localparam int SUPPLY_ERR_BIT = 3;
    localparam int PROG_SUSP_BIT  = 2;
    localparam int LOCKED_BIT     = 1;
    // controller register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    // operation codes written to REG_CTRL[3:0]
    localparam logic [3:0] OP_PROGRAM   = 4'h1;
    localparam logic [3:0] OP_ERASE     = 4'h2;
    localparam logic [3:0] OP_PROT_PROG = 4'h3;
    localparam logic [3:0] OP_SUSPEND   = 4'h4;
    localparam logic [3:0] OP_RESUME    = 4'h5;
    localparam logic [3:0] OP_READ      = 4'h6;
    localparam logic [3:0] OP_CLEAR     = 4'h7;
    localparam logic [3:0] OP_STATUS    = 4'h8;
    // bus timing in ns and derived cycles at 50 MHz
    localparam int CLK_NS      = 20;
    localparam int PULSE_NS    = 80;
    localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {FPES_BUS_IDLE, FPES_BUS_ACT, FPES_BUS_GAP}
        fpes_bus_state_t;
endpackage : fpes_pkg

// [fpes_bus_cycle.sv]
`timescale 1ns/1ps
// one asynchronous write or read cycle on the flash pins
module fpes_bus_cycle #(
    parameter int AW = 21,
    parameter int PULSE = fpes_pkg::PULSE_CYC
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          start,
    input  wire logic          is_write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   wdata,
    output logic               done,
    output logic [15:0]        rdata,
    output logic [AW-1:0]      flash_addr,
    output logic               flash_ce_n,
    output logic               flash_oe_n,
    output logic               flash_we_n,
    output logic [15:0]        flash_dq_o,
    output logic               flash_dq_oe,
    input  wire logic [15:0]   flash_dq_i
);
    fpes_pkg::fpes_bus_state_t state;
    logic [7:0]  cnt;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic        wr;

    always_ff @(posedge aclk) begin
        dq_s1 <= flash_dq_i;
        dq_s2 <= dq_s1;
    end

    // ce is raised between cycles so every read samples fresh status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= fpes_pkg::FPES_BUS_IDLE;
            cnt         <= 8'h00;
            wr          <= 1'b0;
            done        <= 1'b0;
            rdata       <= 16'h0000;
            flash_addr  <= '0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            flash_dq_o  <= 16'h0000;
            flash_dq_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                fpes_pkg::FPES_BUS_IDLE: begin
                    if (start) begin
                        state       <= fpes_pkg::FPES_BUS_ACT;
                        cnt         <= 8'(PULSE + 2);
                        wr          <= is_write;
                        flash_addr  <= addr;
                        flash_dq_o  <= wdata;
                        flash_dq_oe <= is_write;
                        flash_ce_n  <= 1'b0;
                        flash_we_n  <= !is_write;
                        flash_oe_n  <= is_write;
                    end
                end
                fpes_pkg::FPES_BUS_ACT: begin
                    if (cnt == 8'h00) begin
                        if (!wr) begin
                            rdata <= dq_s2;
                        end
                        flash_ce_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        cnt        <= 8'(PULSE);
                        state      <= fpes_pkg::FPES_BUS_GAP;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                fpes_pkg::FPES_BUS_GAP: begin
                    if (cnt == 8'h00) begin
                        flash_dq_oe <= 1'b0;
                        done        <= 1'b1;
                        state       <= fpes_pkg::FPES_BUS_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= fpes_pkg::FPES_BUS_IDLE;
            endcase
        end
    end
endmodule : fpes_bus_cycle

// [fpes_host.sv]
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module fpes_host #(
    parameter int AW = 21
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [AW-1:0]      flash_addr,
    output logic               flash_ce_n,
    output logic               flash_oe_n,
    output logic               flash_we_n,
    output logic [15:0]        flash_dq_o,
    output logic               flash_dq_oe,
    input  wire logic [15:0]   flash_dq_i
);
    typedef enum logic [2:0] {
        FPES_IDLE, FPES_CMD1, FPES_CMD2, FPES_POLL, FPES_READ
    } fpes_state_t;

    fpes_state_t     state;
    logic [AW-1:0]   op_addr;
    logic [15:0]     op_data;
    logic [3:0]      op;
    logic [7:0]      status;
    logic [15:0]     read_word;
    logic            busy;
    logic            refused;
    logic            in_status_mode;
    logic            aw_held;
    logic            w_held;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            cyc_start;
    logic            cyc_write;
    logic [AW-1:0]   cyc_addr;
    logic [15:0]     cyc_wdata;
    logic            cyc_done;
    logic [15:0]     cyc_rdata;
    logic            wr_fire;
    logic            go;
    logic [7:0]      first_code;
    logic [7:0]      second_code;
    logic            two_cycle;
    logic            needs_poll;
    logic            blocked;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign go = wr_fire && aw_addr == fpes_pkg::REG_CTRL && w_strb[0]
                && !busy;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == fpes_pkg::REG_CTRL ||
                             aw_addr == fpes_pkg::REG_ADDR ||
                             aw_addr == fpes_pkg::REG_DATA) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_addr <= '0;
            op_data <= 16'h0000;
        end else if (wr_fire) begin
            if (aw_addr == fpes_pkg::REG_ADDR) begin
                op_addr <= w_data[AW-1:0];
            end
            if (aw_addr == fpes_pkg::REG_DATA) begin
                op_data <= w_data[15:0];
            end
        end
    end

    // the device refuses these itself; stopping here saves the command and poll bus cycles
    always_comb begin
        blocked = 1'b0;
        case (w_data[3:0])
            fpes_pkg::OP_PROGRAM, fpes_pkg::OP_PROT_PROG:
                blocked = status[fpes_pkg::SUPPLY_ERR_BIT];
            fpes_pkg::OP_ERASE:
                blocked = status[fpes_pkg::SUPPLY_ERR_BIT] ||
                          status[fpes_pkg::LOCKED_BIT];
            default: blocked = 1'b0;
        endcase
    end

    always_comb begin
        first_code  = fpes_pkg::CMD_READ;
        second_code = op_data[7:0];
        two_cycle   = 1'b0;
        needs_poll  = 1'b0;
        case (op)
            fpes_pkg::OP_PROGRAM: begin
                first_code = fpes_pkg::CMD_PROGRAM;
                two_cycle  = 1'b1;
                needs_poll = 1'b1;
            end
            fpes_pkg::OP_ERASE: begin
                first_code  = fpes_pkg::CMD_ERASE;
                second_code = fpes_pkg::CMD_CONFIRM;
                two_cycle   = 1'b1;
                needs_poll  = 1'b1;
            end
            fpes_pkg::OP_PROT_PROG: begin
                first_code = fpes_pkg::CMD_PROT_PROG;
                two_cycle  = 1'b1;
                needs_poll = 1'b1;
            end
            fpes_pkg::OP_SUSPEND: begin
                first_code  = fpes_pkg::CMD_STATUS;
                second_code = fpes_pkg::CMD_SUSPEND;
                two_cycle   = 1'b1;
                needs_poll  = 1'b1;
            end
            fpes_pkg::OP_RESUME: first_code = fpes_pkg::CMD_CONFIRM;
            fpes_pkg::OP_READ:   first_code = fpes_pkg::CMD_READ;
            fpes_pkg::OP_CLEAR:  first_code = fpes_pkg::CMD_CLEAR;
            fpes_pkg::OP_STATUS: begin
                first_code = fpes_pkg::CMD_STATUS;
                needs_poll = 1'b1;
            end
            default: first_code = fpes_pkg::CMD_READ;
        endcase
    end

    assign busy = state != FPES_IDLE;

    always_comb begin
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_addr  = op_addr;
        cyc_wdata = {8'h00, first_code};
        case (state)
            FPES_CMD1: cyc_start = 1'b1;
            FPES_CMD2: begin
                cyc_start = 1'b1;
                cyc_wdata = (op == fpes_pkg::OP_PROGRAM ||
                             op == fpes_pkg::OP_PROT_PROG) ? op_data
                                                           : {8'h00, second_code};
            end
            FPES_POLL, FPES_READ: begin
                cyc_start = 1'b1;
                cyc_write = 1'b0;
            end
            default: cyc_start = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state          <= FPES_IDLE;
            op             <= 4'h0;
            status         <= 8'h00;
            read_word      <= 16'h0000;
            refused        <= 1'b0;
            in_status_mode <= 1'b0;
        end else begin
            case (state)
                FPES_IDLE: begin
                    if (go && blocked) begin
                        refused <= 1'b1;
                    end else if (go) begin
                        refused <= 1'b0;
                        op      <= w_data[3:0];
                        state   <= FPES_CMD1;
                    end else if (wr_fire && aw_addr == fpes_pkg::REG_ADDR
                                 && !in_status_mode) begin
                        state <= FPES_READ;
                    end
                end
                FPES_CMD1: begin
                    if (cyc_done) begin
                        if (two_cycle) begin
                            state <= FPES_CMD2;
                        end else if (needs_poll) begin
                            state <= FPES_POLL;
                        end else begin
                            state <= FPES_IDLE;
                        end
                        if (op == fpes_pkg::OP_READ) begin
                            in_status_mode <= 1'b0;
                        end
                        if (op == fpes_pkg::OP_CLEAR) begin
                            status <= 8'h00;
                        end
                    end
                end
                FPES_CMD2: begin
                    if (cyc_done) begin
                        state          <= FPES_POLL;
                        in_status_mode <= 1'b1;
                    end
                end
                // each poll is a fresh ce cycle
                FPES_POLL: begin
                    if (cyc_done) begin
                        status <= cyc_rdata[7:0];
                        if (cyc_rdata[fpes_pkg::READY_BIT]) begin
                            state <= FPES_IDLE;
                        end
                    end
                end
                FPES_READ: begin
                    if (cyc_done) begin
                        read_word <= cyc_rdata;
                        state     <= FPES_IDLE;
                    end
                end
                default: state <= FPES_IDLE;
            endcase
        end
    end

    fpes_bus_cycle #(
        .AW    (AW),
        .PULSE (fpes_pkg::PULSE_CYC)
    ) u_cycle (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (cyc_start && !cyc_done),
        .is_write    (cyc_write),
        .addr        (cyc_addr),
        .wdata       (cyc_wdata),
        .done        (cyc_done),
        .rdata       (cyc_rdata),
        .flash_addr  (flash_addr),
        .flash_ce_n  (flash_ce_n),
        .flash_oe_n  (flash_oe_n),
        .flash_we_n  (flash_we_n),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_dq_i  (flash_dq_i)
    );

    logic [4:0] err;
    always_comb begin
        err[0] = status[fpes_pkg::PROG_ERR_BIT] &&
                 status[fpes_pkg::ERASE_ERR_BIT];
        err[1] = status[fpes_pkg::ERASE_ERR_BIT] &&
                 !status[fpes_pkg::PROG_ERR_BIT];
        err[2] = status[fpes_pkg::PROG_ERR_BIT] &&
                 !status[fpes_pkg::ERASE_ERR_BIT] &&
                 !status[fpes_pkg::SUPPLY_ERR_BIT] &&
                 !status[fpes_pkg::LOCKED_BIT];
        err[3] = status[fpes_pkg::SUPPLY_ERR_BIT];
        err[4] = status[fpes_pkg::LOCKED_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                fpes_pkg::REG_CTRL:   s_axi_rdata <= {28'h0, op};
                fpes_pkg::REG_ADDR:   s_axi_rdata <= 32'(op_addr);
                fpes_pkg::REG_DATA:   s_axi_rdata <= {16'h0000, op_data};
                fpes_pkg::REG_STATUS: s_axi_rdata <= {12'h000, err,
                    4'h0, in_status_mode, refused, busy, status};
                fpes_pkg::REG_RDATA:  s_axi_rdata <= {16'h0000, read_word};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : fpes_host

// [fpes_host_assertions.sv]
`timescale 1ns/1ps
module fpes_host_checker #(
    parameter int AW = 21
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic [AW-1:0] flash_addr,
    input wire logic          flash_ce_n,
    input wire logic          flash_oe_n,
    input wire logic          flash_we_n,
    input wire logic          flash_dq_oe
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence strobe_low(logic s);
        !s [*7] ##1 s;
    endsequence
    sequence pins_idle;
        (flash_ce_n && flash_oe_n && flash_we_n) [*5];
    endsequence
    write_pulse_a: assert property (
        $fell(flash_we_n) |-> strobe_low(flash_we_n))
        else $error("write strobe width");
    read_pulse_a: assert property (
        $fell(flash_oe_n) |-> strobe_low(flash_oe_n))
        else $error("read strobe width");
    cycle_gap_a: assert property (
        $rose(flash_ce_n) |-> pins_idle)
        else $error("select gap short");
    read_drive_a: assert property (
        !flash_oe_n |-> !flash_ce_n && !flash_dq_oe && flash_we_n)
        else $error("read contention");
    write_drive_a: assert property (
        !flash_we_n |-> !flash_ce_n && flash_dq_oe)
        else $error("write undriven");
    addr_hold_a: assert property (
        !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
        else $error("address moved");
    wresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    rresp_time_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
endmodule : fpes_host_checker

// [fpes_flash_model.sv]
`timescale 1ns/1ps
module fpes_flash_model #(
    parameter int AW        = 21,
    parameter int PROG_CYC  = 40,
    parameter int ERASE_CYC = 60
) (
    input wire logic          aclk,
    input wire logic [AW-1:0] flash_addr,
    input wire logic          flash_ce_n,
    input wire logic          flash_oe_n,
    input wire logic          flash_we_n,
    input wire logic [15:0]   flash_dq_o,
    input wire logic          flash_dq_oe,
    output logic [15:0]       flash_dq_i,
    input wire logic          locked,
    input wire logic          vpp_low,
    input wire logic          op_fail
);
    logic [15:0]   mem [int];
    logic [15:0]   last = 16'h0000;
    logic [15:0]   drv = 16'h0000;
    logic [15:0]   cmd = 16'h0000;
    logic [AW-1:0] cad = '0;
    logic [7:0]    sr = 8'h00;
    logic [7:0]    sr_q = 8'h00;
    logic [1:0]    setup = 2'h0;
    logic          we_d = 1'b1;
    logic          stat_mode = 1'b0;
    logic          erasing = 1'b0;
    int            busy = 0;
    int            held = 0;
    always @(negedge flash_oe_n) sr_q = {busy == 0, sr[6:0]};
    // released bus shows inverse of last value
    assign flash_dq_i = (flash_ce_n || flash_oe_n) ? ~last : drv;
    always @(posedge aclk) begin
        we_d <= flash_we_n;
        // status on low byte until array read
        drv <= stat_mode ? {8'h00, sr_q} : (mem.exists(int'(flash_addr))
            ? mem[int'(flash_addr)] : 16'hFFFF);
        if (!flash_ce_n && !flash_oe_n) last <= drv;
        if (!flash_we_n && flash_dq_oe) begin
            cmd <= flash_dq_o;
            cad <= flash_addr;
        end
        if (busy > 0) busy <= busy - 1;
        if (flash_we_n && !we_d) begin
            setup <= 2'h0;
            stat_mode <= 1'b1;
            case (setup)
            2'h1: begin
                if (vpp_low || sr[3]) sr[4:3] <= 2'h3;
                else if (locked) sr[1] <= 1'b1;
                else if (op_fail) sr[4] <= 1'b1;
                else begin
                    mem[int'(cad)] = cmd;
                    busy <= PROG_CYC;
                    erasing <= 1'b0;
                end
            end
            2'h2: begin
                if (cmd[7:0] != 8'hD0) sr[5:4] <= 2'h3;
                else if (sr[1] || sr[3] || vpp_low) sr[3] <= sr[3] | vpp_low;
                else if (locked) sr[1] <= 1'b1;
                else if (op_fail) sr[5] <= 1'b1;
                else begin
                    mem.delete();
                    busy <= ERASE_CYC;
                    erasing <= 1'b1;
                end
            end
            2'h3: begin
                if (cad[AW-1:8] != '0 || cad[7:0] < 8'h81 || cad[7:0] > 8'h88)
                    sr[4] <= 1'b1;
                else if (vpp_low) sr[4:3] <= 2'h3;
                else if (cad[7:0] < 8'h85) sr[4:1] <= 4'h9;
                else busy <= PROG_CYC;
            end
            default: begin
                case (cmd[7:0])
                8'h40: setup <= 2'h1;
                8'h20: setup <= 2'h2;
                8'hC0: setup <= 2'h3;
                8'h50: sr <= sr & 8'hC4;
                8'hFF: stat_mode <= 1'b0;
                8'hB0: if (busy > 0) begin
                    held <= busy;
                    busy <= 0;
                    sr[erasing ? 6 : 2] <= 1'b1;
                end
                8'hD0: if (held > 0) begin
                    busy <= held;
                    held <= 0;
                    sr[6] <= 1'b0;
                    sr[2] <= 1'b0;
                end
                default: stat_mode <= 1'b1;
                endcase
            end
            endcase
        end
    end
endmodule : fpes_flash_model

// [fpes_host_bench.sv]
`timescale 1ns/1ps
module fpes_host_bench;
    logic aclk = 1'b0, aresetn = 1'b0, locked = 1'b0, vpp_low = 1'b0;
    logic op_fail = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [20:0] flash_addr;
    logic [15:0] flash_dq_o, flash_dq_i;
    int num_errors = 0;
    int checks = 0;
    always #10 aclk = ~aclk;
    fpes_host #(.AW(21)) DUT (.*);
    fpes_flash_model #(.AW(21)) flash (.*);
    task results;
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task wait_idle(output logic [31:0] st);
        logic [1:0] r;
        repeat (300) begin
            rd(fpes_pkg::REG_STATUS, st, r);
            if (st[8] === 1'b0) break;
        end
    endtask : wait_idle
    task op(input logic [3:0] code, input logic [20:0] a,
            input logic [15:0] d, output logic [31:0] st);
        logic [1:0] r;
        wr(fpes_pkg::REG_DATA, 32'(d), r);
        wr(fpes_pkg::REG_ADDR, 32'(a), r);
        wait_idle(st);
        wr(fpes_pkg::REG_CTRL, 32'(code), r);
        wait_idle(st);
    endtask : op
    task arr_rd(input logic [20:0] a, input logic [15:0] exp);
        logic [31:0] st;
        logic [1:0] r;
        op(fpes_pkg::OP_READ, a, 16'h0000, st);
        wr(fpes_pkg::REG_ADDR, 32'(a), r);
        wait_idle(st);
        rd(fpes_pkg::REG_RDATA, st, r);
        chk(st, 32'(exp));
    endtask : arr_rd
    task clr;
        logic [31:0] st;
        op(fpes_pkg::OP_CLEAR, 21'h0, 16'h0, st);
        op(fpes_pkg::OP_STATUS, 21'h0, 16'h0, st);
        chk(st & 32'h000F80FF, 32'h80);
    endtask : clr
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd(fpes_pkg::REG_STATUS, d, r);
        chk(d, 32'h0);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'h2);
        wr(fpes_pkg::REG_STATUS, 32'h0, r);
        chk(32'(r), 32'h2);
    endtask : t_regs
    task t_program;
        logic [31:0] st;
        op(fpes_pkg::OP_PROGRAM, 21'h00123, 16'hA5C3, st);
        chk(st & 32'h000F80FF, 32'h80);
        arr_rd(21'h00123, 16'hA5C3);
    endtask : t_program
    task t_lock;
        logic [31:0] st;
        locked <= 1'b1;
        op(fpes_pkg::OP_PROGRAM, 21'h10000, 16'h5555, st);
        chk(st & 32'h2, 32'h2);
        clr;
        op(fpes_pkg::OP_ERASE, 21'h10000, 16'h0, st);
        chk(st & 32'h000802FF, 32'h00080082);
        op(fpes_pkg::OP_ERASE, 21'h10000, 16'h0, st);
        chk(st & 32'h200, 32'h200);
        locked <= 1'b0;
        clr;
    endtask : t_lock
    task t_supply;
        logic [31:0] st;
        vpp_low <= 1'b1;
        op(fpes_pkg::OP_PROGRAM, 21'h00200, 16'h1111, st);
        chk(st & 32'h000402FF, 32'h00040098);
        op(fpes_pkg::OP_PROGRAM, 21'h00200, 16'h1111, st);
        chk(st & 32'h200, 32'h200);
        op(fpes_pkg::OP_ERASE, 21'h00200, 16'h0, st);
        chk(st & 32'h200, 32'h200);
        vpp_low <= 1'b0;
        clr;
    endtask : t_supply
    task t_fail;
        logic [31:0] st;
        op_fail <= 1'b1;
        op(fpes_pkg::OP_PROGRAM, 21'h00300, 16'h2222, st);
        chk(st & 32'h000200FF, 32'h00020090);
        clr;
        op(fpes_pkg::OP_ERASE, 21'h08000, 16'h0, st);
        chk(st & 32'h000180FF, 32'h000100A0);
        op_fail <= 1'b0;
        clr;
    endtask : t_fail
    task t_prot;
        logic [31:0] st;
        op(fpes_pkg::OP_PROT_PROG, 21'h00086, 16'h1234, st);
        chk(st & 32'hFF, 32'h80);
        op(fpes_pkg::OP_PROT_PROG, 21'h00090, 16'h1234, st);
        chk(st & 32'hFF, 32'h90);
        clr;
        op(fpes_pkg::OP_PROT_PROG, 21'h00081, 16'h1234, st);
        chk(st & 32'hFF, 32'h92);
        clr;
    endtask : t_prot
    task t_erase;
        logic [31:0] st;
        op(fpes_pkg::OP_ERASE, 21'h00100, 16'h0, st);
        chk(st & 32'h000F80FF, 32'h80);
        arr_rd(21'h00123, 16'hFFFF);
    endtask : t_erase
    task t_suspend;
        logic [31:0] st;
        op(fpes_pkg::OP_SUSPEND, 21'h0, 16'h0, st);
        chk(st & 32'hFF, 32'h80);
        op(fpes_pkg::OP_RESUME, 21'h0, 16'h0, st);
        op(fpes_pkg::OP_STATUS, 21'h0, 16'h0, st);
        chk(st & 32'hFF, 32'h80);
    endtask : t_suspend
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_program;
        t_lock;
        t_supply;
        t_fail;
        t_prot;
        t_erase;
        t_suspend;
        results;
    end
    initial begin
        repeat (80000) @(posedge aclk);
        num_errors++;
        results;
    end
endmodule : fpes_host_bench
bind fpes_host fpes_host_checker #(.AW(AW)) u_chk (.*);
